// [hdl/ipb_interrupt_priority_bank.sv]
// Interrupt priority register bank with per-source priority outputs
//
// Operation
// - Code 111 means level 7, highest
// - Code 001 means level 1, lowest live
// - Code 000 disables the source entirely
// - Every field resets to 100, level 4
// - Fields at 14-12, 10-8, 6-4, 2-0
// - Capture 8/7 upper fields, ext1 bits 2-0
// - Timer4, compare4, compare3, transfer2 done register
// - UART B tx/rx, ext2, timer5 register
// - Transfer 3 done alone in bits 2-0
// - No CAN controller: CAN sources never fire
// - Pin change, comparator, I2C master/slave register
// - Audio error priority alone at bits 14-12
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`default_nettype none
module ipb_interrupt_priority_bank #(
   parameter bit HAS_CAN = 1'b1   // Variant carries the CAN controller
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [ipb_pkg::AW-1:0] reg_addr,
   input wire logic [ipb_pkg::DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [ipb_pkg::DW-1:0] reg_rdata_ff,
   output ipb_pkg::ipb_prio_t prio_ff,
   output logic [ipb_pkg::NUM_SRC-1:0] src_live_ff
);
   // ****************************************
   // Register storage
   // ****************************************
   logic [ipb_pkg::NUM_REGS-1:0][ipb_pkg::DW-1:0] regs_ff; // Bank
   logic [ipb_pkg::NUM_REGS-1:0][ipb_pkg::DW-1:0] nxt_regs;
   logic [ipb_pkg::DW-1:0] nxt_reg_rdata;
   ipb_pkg::ipb_prio_t nxt_prio;
   logic [ipb_pkg::NUM_SRC-1:0] nxt_src_live;
   logic [ipb_pkg::NUM_SRC*ipb_pkg::FW-1:0] prio_vec; // Flat view
   logic hit;                      // Address lands in the bank

   // Indices past the bank are ignored on write and read as zero
   assign hit = (reg_addr < ipb_pkg::AW'(ipb_pkg::NUM_REGS));

   // Write path: only implemented bits can change
   always_comb
   begin
      nxt_regs = regs_ff;
      if (reg_wr && hit)
      begin
         nxt_regs[reg_addr[2:0]] =
            reg_wdata & ipb_pkg::REG_MASK[reg_addr[2:0]];
      end
   end

   // One flop group per register; reset puts 100 in each field
   genvar gi;
   generate
      for (gi = 0; gi < ipb_pkg::NUM_REGS; gi++)
      begin : g_reg
         always_ff @(posedge mclk)
         begin
            if (srst)
            begin
               regs_ff[gi] <= ipb_pkg::REG_MASK[gi] &
                  ipb_pkg::FIELD_RESET_PATTERN;
            end
            else
            begin
               regs_ff[gi] <= nxt_regs[gi];
            end
         end

         // Unimplemented bits must never hold a one
         a_reg_masked:
         assert property (@(posedge mclk) disable iff (srst)
            (regs_ff[gi] & ~ipb_pkg::REG_MASK[gi]) == '0)
         else $error("Unimplemented register bit set");
      end
   endgenerate

   // ****************************************
   // Read path
   // ****************************************
   // Data valid only in the cycle after the strobe, zero otherwise
   always_comb
   begin
      nxt_reg_rdata = '0;
      if (reg_rd && hit)
      begin
         nxt_reg_rdata = regs_ff[reg_addr[2:0]];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         reg_rdata_ff <= '0;
      end
      else
      begin
         reg_rdata_ff <= nxt_reg_rdata;
      end
   end

   // Reads outside the bank return zero, not a stale word
   a_unmapped_read:
   assert property (@(posedge mclk) disable iff (srst)
      reg_rd && !hit |=> reg_rdata_ff == '0)
   else $error("Unmapped read returned data");

   // The word stands one cycle only; nothing holds it longer
   a_rdata_once:
   assert property (@(posedge mclk) disable iff (srst)
      !reg_rd |=> reg_rdata_ff == '0)
   else $error("Read data outside its cycle");

   // ****************************************
   // Field extraction
   // ****************************************
   // The field value is the level itself, so no decode is needed;
   // the arbiter compares these codes directly
   always_comb
   begin
      nxt_prio.pin_change_prio = regs_ff[ipb_pkg::REG_CHANGE_CMP_I2C]
         [ipb_pkg::FLD3_LSB +: ipb_pkg::FW];
      nxt_prio.comparator_prio = regs_ff[ipb_pkg::REG_CHANGE_CMP_I2C]
         [ipb_pkg::FLD2_LSB +: ipb_pkg::FW];
      nxt_prio.i2c_master_event_prio =
         regs_ff[ipb_pkg::REG_CHANGE_CMP_I2C]
         [ipb_pkg::FLD1_LSB +: ipb_pkg::FW];
      nxt_prio.i2c_slave_event_prio =
         regs_ff[ipb_pkg::REG_CHANGE_CMP_I2C]
         [ipb_pkg::FLD0_LSB +: ipb_pkg::FW];
      nxt_prio.capture_ch8_prio = regs_ff[ipb_pkg::REG_CAPTURE_EXT1]
         [ipb_pkg::FLD3_LSB +: ipb_pkg::FW];
      nxt_prio.capture_ch7_prio = regs_ff[ipb_pkg::REG_CAPTURE_EXT1]
         [ipb_pkg::FLD2_LSB +: ipb_pkg::FW];
      nxt_prio.ext_irq1_prio = regs_ff[ipb_pkg::REG_CAPTURE_EXT1]
         [ipb_pkg::FLD0_LSB +: ipb_pkg::FW];
      nxt_prio.timer_four_prio =
         regs_ff[ipb_pkg::REG_TIMER4_COMPARE_DMA2]
         [ipb_pkg::FLD3_LSB +: ipb_pkg::FW];
      nxt_prio.compare_ch4_prio =
         regs_ff[ipb_pkg::REG_TIMER4_COMPARE_DMA2]
         [ipb_pkg::FLD2_LSB +: ipb_pkg::FW];
      nxt_prio.compare_ch3_prio =
         regs_ff[ipb_pkg::REG_TIMER4_COMPARE_DMA2]
         [ipb_pkg::FLD1_LSB +: ipb_pkg::FW];
      nxt_prio.xfer_ch2_done_prio =
         regs_ff[ipb_pkg::REG_TIMER4_COMPARE_DMA2]
         [ipb_pkg::FLD0_LSB +: ipb_pkg::FW];
      nxt_prio.uart_b_tx_prio = regs_ff[ipb_pkg::REG_UART2_EXT2_TIMER5]
         [ipb_pkg::FLD3_LSB +: ipb_pkg::FW];
      nxt_prio.uart_b_rx_prio = regs_ff[ipb_pkg::REG_UART2_EXT2_TIMER5]
         [ipb_pkg::FLD2_LSB +: ipb_pkg::FW];
      nxt_prio.ext_irq2_prio = regs_ff[ipb_pkg::REG_UART2_EXT2_TIMER5]
         [ipb_pkg::FLD1_LSB +: ipb_pkg::FW];
      nxt_prio.timer_five_prio = regs_ff[ipb_pkg::REG_UART2_EXT2_TIMER5]
         [ipb_pkg::FLD0_LSB +: ipb_pkg::FW];
      nxt_prio.can_event_prio = regs_ff[ipb_pkg::REG_CAN_SPI2]
         [ipb_pkg::FLD3_LSB +: ipb_pkg::FW];
      nxt_prio.can_rx_ready_prio = regs_ff[ipb_pkg::REG_CAN_SPI2]
         [ipb_pkg::FLD2_LSB +: ipb_pkg::FW];
      nxt_prio.spi_b_event_prio = regs_ff[ipb_pkg::REG_CAN_SPI2]
         [ipb_pkg::FLD1_LSB +: ipb_pkg::FW];
      nxt_prio.spi_b_error_prio = regs_ff[ipb_pkg::REG_CAN_SPI2]
         [ipb_pkg::FLD0_LSB +: ipb_pkg::FW];
      nxt_prio.xfer_ch3_done_prio = regs_ff[ipb_pkg::REG_DMA_CH3]
         [ipb_pkg::FLD0_LSB +: ipb_pkg::FW];
      nxt_prio.xfer_ch4_done_prio =
         regs_ff[ipb_pkg::REG_DMA4_PARALLEL_PORT]
         [ipb_pkg::FLD2_LSB +: ipb_pkg::FW];
      nxt_prio.parallel_port_prio =
         regs_ff[ipb_pkg::REG_DMA4_PARALLEL_PORT]
         [ipb_pkg::FLD1_LSB +: ipb_pkg::FW];
      nxt_prio.audio_iface_error_prio =
         regs_ff[ipb_pkg::REG_AUDIO_IFACE_ERROR]
         [ipb_pkg::FLD3_LSB +: ipb_pkg::FW];
      // Without the CAN block the fields stay readable but never rank
      if (!HAS_CAN)
      begin
         nxt_prio.can_event_prio = ipb_pkg::PRIO_OFF;
         nxt_prio.can_rx_ready_prio = ipb_pkg::PRIO_OFF;
      end
   end

   // ****************************************
   // Source liveness
   // ****************************************
   // Code 000 removes the source from arbitration regardless of
   // its flag and enable
   assign prio_vec = nxt_prio;
   generate
      for (gi = 0; gi < ipb_pkg::NUM_SRC; gi++)
      begin : g_live
         assign nxt_src_live[gi] =
            (prio_vec[gi*ipb_pkg::FW +: ipb_pkg::FW] !=
             ipb_pkg::PRIO_OFF);
      end
   endgenerate

   // Output stage, one cycle behind the register bank
   // Registered so the arbiter sees glitch-free levels; costs a cycle
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         prio_ff <= '0;
         src_live_ff <= '0;
      end
      else
      begin
         prio_ff <= nxt_prio;
         src_live_ff <= nxt_src_live;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_reset_level:
   assert property (@(posedge mclk) srst ##1 !srst |->
      regs_ff[ipb_pkg::REG_CHANGE_CMP_I2C] == 16'h4444 &&
      regs_ff[ipb_pkg::REG_AUDIO_IFACE_ERROR] == 16'h4000)
   else $error("Priority fields not at level 4 after reset");

   a_off_not_live:
   assert property (@(posedge mclk) disable iff (srst)
      prio_ff.timer_five_prio == ipb_pkg::PRIO_OFF |-> !src_live_ff[8])
   else $error("Disabled source still live");

   a_max_level:
   assert property (@(posedge mclk) disable iff (srst)
      reg_wr && reg_addr == ipb_pkg::REG_CHANGE_CMP_I2C &&
      reg_wdata == 16'hFFFF ##1 !reg_wr |=>
      prio_ff.pin_change_prio == 3'h7 && src_live_ff[22])
   else $error("Code 111 did not give level 7");

   a_min_level:
   assert property (@(posedge mclk) disable iff (srst)
      reg_wr && reg_addr == ipb_pkg::REG_TIMER4_COMPARE_DMA2 &&
      reg_wdata == 16'h1111 ##1 !reg_wr |=>
      prio_ff.xfer_ch2_done_prio == 3'h1 && src_live_ff[12])
   else $error("Code 001 did not give live level 1");

   a_unimpl_read:
   assert property (@(posedge mclk) disable iff (srst)
      reg_rd && reg_addr == ipb_pkg::REG_DMA_CH3 |=>
      reg_rdata_ff[15:3] == 13'h0)
   else $error("Unimplemented bits read nonzero");

   a_ext1_field:
   assert property (@(posedge mclk) disable iff (srst)
      reg_wr && reg_addr == ipb_pkg::REG_CAPTURE_EXT1 ##1 !reg_wr |=>
      prio_ff.ext_irq1_prio == $past(reg_wdata[2:0], 2) &&
      regs_ff[ipb_pkg::REG_CAPTURE_EXT1][7:3] == 5'h0)
   else $error("External 1 field misplaced");

   a_uart_field:
   assert property (@(posedge mclk) disable iff (srst)
      reg_wr && reg_addr == ipb_pkg::REG_UART2_EXT2_TIMER5 ##1 !reg_wr
      |=> prio_ff.uart_b_tx_prio == $past(reg_wdata[14:12], 2))
   else $error("UART B transmit field misplaced");

   a_audio_field:
   assert property (@(posedge mclk) disable iff (srst)
      reg_wr && reg_addr == ipb_pkg::REG_AUDIO_IFACE_ERROR ##1 !reg_wr
      |=> prio_ff.audio_iface_error_prio == $past(reg_wdata[14:12], 2)
      && regs_ff[ipb_pkg::REG_AUDIO_IFACE_ERROR][11:0] == 12'h0)
   else $error("Audio error field misplaced");

   a_can_gated:
   assert property (@(posedge mclk) disable iff (srst)
      !HAS_CAN |-> !src_live_ff[7] && !src_live_ff[6])
   else $error("CAN source live on variant without CAN");

   // A field reaches the arbiter unchanged one cycle after the bank
   a_level_follow:
   assert property (@(posedge mclk) disable iff (srst)
      !$past(srst) |-> prio_ff.xfer_ch3_done_prio ==
      $past(regs_ff[ipb_pkg::REG_DMA_CH3][2:0]))
   else $error("Priority output does not follow its field");

   // Top field of the timer four register
   a_timer4_field:
   assert property (@(posedge mclk) disable iff (srst)
      reg_wr && reg_addr == ipb_pkg::REG_TIMER4_COMPARE_DMA2 ##1 !reg_wr
      |=> prio_ff.timer_four_prio == $past(reg_wdata[14:12], 2))
   else $error("Timer four field misplaced");

   // Bottom field of the pin change register
   a_i2c_field:
   assert property (@(posedge mclk) disable iff (srst)
      reg_wr && reg_addr == ipb_pkg::REG_CHANGE_CMP_I2C ##1 !reg_wr |=>
      prio_ff.i2c_slave_event_prio == $past(reg_wdata[2:0], 2))
   else $error("I2C slave field misplaced");

   // Top field of the capture register
   a_capture_field:
   assert property (@(posedge mclk) disable iff (srst)
      reg_wr && reg_addr == ipb_pkg::REG_CAPTURE_EXT1 ##1 !reg_wr |=>
      prio_ff.capture_ch8_prio == $past(reg_wdata[14:12], 2))
   else $error("Capture channel 8 field misplaced");
endmodule // ipb_interrupt_priority_bank
`default_nettype wire

// [hdl/ipb_pkg.sv]
// Package for the interrupt priority bank: map, layouts, reset values
`default_nettype none
package ipb_pkg;
   // ****************************************
   // Bus geometry
   // ****************************************
   localparam int NUM_REGS = 8;      // Priority registers in the bank
   localparam int AW = 4;            // Register index width
   localparam int DW = 16;           // Register width
   localparam int FW = 3;            // Priority field width
   localparam int NUM_SRC = 23;      // Priority sources held
   // ****************************************
   // Register indices
   // ****************************************
   localparam logic [AW-1:0] REG_CHANGE_CMP_I2C = 4'h0;
   localparam logic [AW-1:0] REG_CAPTURE_EXT1 = 4'h1;
   localparam logic [AW-1:0] REG_TIMER4_COMPARE_DMA2 = 4'h2;
   localparam logic [AW-1:0] REG_UART2_EXT2_TIMER5 = 4'h3;
   localparam logic [AW-1:0] REG_CAN_SPI2 = 4'h4;
   localparam logic [AW-1:0] REG_DMA_CH3 = 4'h5;
   localparam logic [AW-1:0] REG_DMA4_PARALLEL_PORT = 4'h6;
   localparam logic [AW-1:0] REG_AUDIO_IFACE_ERROR = 4'h7;
   // ****************************************
   // Field layout and codes
   // ****************************************
   localparam int FLD3_LSB = 12;     // Bits 14-12
   localparam int FLD2_LSB = 8;      // Bits 10-8
   localparam int FLD1_LSB = 4;      // Bits 6-4
   localparam int FLD0_LSB = 0;      // Bits 2-0
   // Implemented bits per register, index 0 in the low word
   localparam logic [NUM_REGS-1:0][DW-1:0] REG_MASK = {
      16'h7000, 16'h0770, 16'h0007, 16'h7777,
      16'h7777, 16'h7777, 16'h7707, 16'h7777};
   localparam logic [DW-1:0] FIELD_RESET_PATTERN = 16'h4444; // Code 100
   localparam logic [FW-1:0] PRIO_OFF = 3'h0;  // Source disabled
   localparam logic [FW-1:0] PRIO_MIN = 3'h1;  // Lowest live level
   localparam logic [FW-1:0] PRIO_MAX = 3'h7;  // Highest level
   localparam logic [FW-1:0] PRIO_RESET = 3'h4;
   // ****************************************
   // Per-source priority carrier
   // ****************************************
   typedef struct packed {
      logic [FW-1:0] pin_change_prio;
      logic [FW-1:0] comparator_prio;
      logic [FW-1:0] i2c_master_event_prio;
      logic [FW-1:0] i2c_slave_event_prio;
      logic [FW-1:0] capture_ch8_prio;
      logic [FW-1:0] capture_ch7_prio;
      logic [FW-1:0] ext_irq1_prio;
      logic [FW-1:0] timer_four_prio;
      logic [FW-1:0] compare_ch4_prio;
      logic [FW-1:0] compare_ch3_prio;
      logic [FW-1:0] xfer_ch2_done_prio;
      logic [FW-1:0] uart_b_tx_prio;
      logic [FW-1:0] uart_b_rx_prio;
      logic [FW-1:0] ext_irq2_prio;
      logic [FW-1:0] timer_five_prio;
      logic [FW-1:0] can_event_prio;
      logic [FW-1:0] can_rx_ready_prio;
      logic [FW-1:0] spi_b_event_prio;
      logic [FW-1:0] spi_b_error_prio;
      logic [FW-1:0] xfer_ch3_done_prio;
      logic [FW-1:0] xfer_ch4_done_prio;
      logic [FW-1:0] parallel_port_prio;
      logic [FW-1:0] audio_iface_error_prio;
   } ipb_prio_t;
endpackage
`default_nettype wire

// [tb/test_ipb_interrupt_priority_bank.sv]
// Self-checking testbench for the interrupt priority register bank
`default_nettype none
module test_ipb_interrupt_priority_bank;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   typedef struct packed {logic [3:0] a; logic [15:0] d;} ipb_row_t;
   logic mclk = 1'b0; // 20 MHz clock
   logic srst = 1'b1; // Held high from time zero
   logic [ipb_pkg::AW-1:0] reg_addr = 4'h0;
   logic [ipb_pkg::DW-1:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [ipb_pkg::DW-1:0] rdata; // Full variant
   logic [ipb_pkg::DW-1:0] rdata_nc; // Variant without CAN
   ipb_pkg::ipb_prio_t prio;
   ipb_pkg::ipb_prio_t prio_nc;
   logic [ipb_pkg::NUM_SRC-1:0] live;
   logic [ipb_pkg::NUM_SRC-1:0] live_nc;
   int fails = 0;
   int checks = 0;
   logic [15:0] sh [8]; // What each register should hold now
   // Implemented bits; kept apart from the package so a bad mask shows
   localparam logic [15:0] MSK [8] = '{16'h7777, 16'h7707, 16'h7777,
      16'h7777, 16'h7777, 16'h0007, 16'h0770, 16'h7000};
   // Ordinary cases; every code 0..7 lands in some field
   localparam ipb_row_t ROWS [12] = '{'{4'h0, 16'hFFFF},
      '{4'h1, 16'hFFFF}, '{4'h2, 16'h8123}, '{4'h3, 16'hC567},
      '{4'h4, 16'h7650}, '{4'h5, 16'hFFFF}, '{4'h6, 16'hFFFF},
      '{4'h7, 16'hFFFF}, '{4'h8, 16'hFFFF}, '{4'hF, 16'hFFFF},
      '{4'h4, 16'h0000}, '{4'h7, 16'h9000}};
   // ****************************************
   // Clock and devices under test
   // ****************************************
   always #25 mclk = ~mclk;
   ipb_interrupt_priority_bank ipb_interrupt_priority_bank_inst (
      .mclk(mclk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_ff(rdata), .prio_ff(prio), .src_live_ff(live));
   // Same bus drives a variant lacking the CAN controller
   ipb_interrupt_priority_bank #(.HAS_CAN(1'b0))
      ipb_interrupt_priority_bank_nocan_inst (
      .mclk(mclk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_ff(rdata_nc), .prio_ff(prio_nc), .src_live_ff(live_nc));
   // ****************************************
   // Expected outputs from the shadow registers
   // ****************************************
   function automatic logic [91:0] exp_out(input bit can);
      logic [68:0] e;
      logic [22:0] l;
      e = {sh[0][14:12], sh[0][10:8], sh[0][6:4], sh[0][2:0],
         sh[1][14:12], sh[1][10:8], sh[1][2:0], sh[2][14:12], sh[2][10:8],
         sh[2][6:4], sh[2][2:0], sh[3][14:12], sh[3][10:8], sh[3][6:4],
         sh[3][2:0], sh[4][14:12], sh[4][10:8], sh[4][6:4], sh[4][2:0],
         sh[5][2:0], sh[6][10:8], sh[6][6:4], sh[7][14:12]};
      // CAN event and receive-ready fields sit at bits 23:18
      if (!can)
      begin
         e[23:18] = 6'h00;
      end
      // A source is live whenever its level is not zero
      for (int i = 0; i < 23; i++)
      begin
         l[i] = |e[3*i +: 3];
      end
      return {e, l};
   endfunction
   // ****************************************
   // Compare and bus tasks
   // ****************************************
   task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_out(input logic [91:0] got, input logic [91:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Write leaves the strobe up; the next rd task lowers it
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      reg_addr <= a;
      reg_wdata <= d;
      if (a < 4'h8)
      begin
         sh[a[2:0]] = d & MSK[a[2:0]];
      end
   endtask
   // Read data is checked in the one cycle it stands, then checked for zero one cycle later
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk_reg(rdata, exp);
      chk_reg(rdata_nc, exp);
      @(posedge mclk);
      #1;
      chk_reg(rdata, 16'h0000);
   endtask
   task automatic chk_outs();
      chk_out({prio, live}, exp_out(1'b1));
      chk_out({prio, live}, exp_out(1'b1));
      chk_out({prio_nc, live_nc}, exp_out(1'b0));
   endtask
   // Every register and one unmapped index back at reset values
   task automatic chk_reset();
      for (int i = 0; i < 8; i++)
      begin
         sh[i] = 16'h4444 & MSK[i];
      end
      for (int i = 0; i < 9; i++)
      begin
         rd(i[3:0], (i < 8) ? sh[i] : 16'h0000);
      end
      chk_outs();
   endtask
   task automatic final_report();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      repeat (12) @(posedge mclk);
      srst <= 1'b0;
      chk_reset();
      // Table rows: write, read straight after, then the outputs
      foreach (ROWS[r])
      begin
         wr(ROWS[r].a, ROWS[r].d);
         rd(ROWS[r].a, (ROWS[r].a < 4'h8) ? sh[ROWS[r].a[2:0]] : 16'h0000);
         chk_outs();
      end
      // Back-to-back writes, then two reads with idle cycles between; the last write
      // is followed by a read so the strobe drops after one cycle
      wr(4'h3, 16'h0000);
      wr(4'h2, 16'h1111);
      rd(4'h2, 16'h1111);
      rd(4'h3, 16'h0000);
      chk_outs();
      // Reset in mid-run clears outputs and reloads level 4
      @(posedge mclk);
      srst <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      chk_out({prio, live}, 92'h0);
      chk_reg(rdata, 16'h0000);
      @(posedge mclk);
      srst <= 1'b0;
      chk_reset();
      final_report();
   end
   // Hang guard, far beyond the roughly 126 cycles the tests need
   initial
   begin
      repeat (4000) @(posedge mclk);
      fails++;
      final_report();
   end
endmodule // test_ipb_interrupt_priority_bank
`default_nettype wire
